// ===== verilog/fie_pkg.sv
`default_nettype none

package fie_pkg;

    // ------------------------------------------------------------
    // processor port
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // enable register offsets (bank index n sits at PATTERN_IRQ_ENABLE_ADDR - n)
    // ------------------------------------------------------------
    localparam logic [8:0] ALARM_ONE_IRQ_ENABLE_ADDR      = 9'h00c;
    localparam logic [8:0] ALARM_TWO_IRQ_ENABLE_ADDR      = 9'h00d;
    localparam logic [8:0] ERROR_IRQ_ENABLE_ADDR          = 9'h00e;
    localparam logic [8:0] COUNT_OVERFLOW_IRQ_ENABLE_ADDR = 9'h00f;
    localparam logic [8:0] TIMER_IRQ_ENABLE_ADDR          = 9'h010;
    localparam logic [8:0] LINK_ONE_IRQ_ENABLE_ADDR       = 9'h011;
    localparam logic [8:0] LINK_TWO_IRQ_ENABLE_ADDR       = 9'h012;
    localparam logic [8:0] PATTERN_IRQ_ENABLE_ADDR        = 9'h013;
    localparam logic [8:0] EN_BASE_ADDR = ALARM_ONE_IRQ_ENABLE_ADDR;
    localparam int         EN_COUNT     = 8;

    // ------------------------------------------------------------
    // status, latch select and counter offsets
    // ------------------------------------------------------------
    localparam logic [8:0] PATTERN_STATUS_ADDR   = 9'h00b;
    localparam logic [8:0] OVERFLOW_STATUS_ADDR  = 9'h007;
    localparam logic [8:0] LATCH_SEL_ADDR        = 9'h046;
    localparam int         LATCH_SEL_BIT         = 0;
    localparam logic [8:0] CNT_BASE_ADDR         = 9'h050;

    // ------------------------------------------------------------
    // bank indices, summary bit positions
    // ------------------------------------------------------------
    localparam int GRP_ALARM_ONE = 7;
    localparam int GRP_ALARM_TWO = 6;
    localparam int GRP_ERROR     = 5;
    localparam int GRP_OVERFLOW  = 4;
    localparam int GRP_TIMER     = 3;
    localparam int GRP_LINK_ONE  = 2;
    localparam int GRP_LINK_TWO  = 1;
    localparam int GRP_PATTERN   = 0;
    localparam int SIGNAL_LOSS_BIT = 3;

    // writable bits per bank, reserved positions clear
    localparam logic [7:0] EN_MASK [EN_COUNT] = '{
        8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, 8'hff};

    // ------------------------------------------------------------
    // reset values and counters
    // ------------------------------------------------------------
    localparam logic [7:0]  EN_RESET      = 8'h00;
    localparam logic        LATCH_RESET   = 1'b0;
    localparam int          CNT_W         = 16;
    localparam int          CNT_NUM       = 8;
    localparam int          PAT_W         = 6;
    localparam logic [15:0] CNT_MAX       = 16'hffff;

endpackage : fie_pkg

`default_nettype wire

// ===== verilog/fie_error_counter.sv
`default_nettype none

module fie_error_counter
    import fie_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_inc,
    input  wire logic       i_roll_en,
    input  wire logic       i_latch_sel,
    input  wire logic       i_tick,
    input  wire logic       i_rd_low,
    input  wire logic       i_rd_high,
    output logic [7:0]      o_low,
    output logic [7:0]      o_high,
    output logic            o_rollover
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] latched;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] next_latched;
    logic [CNT_W-1:0] base;

    always_comb
    begin
        next_latched = latched;
        base         = count;
        o_rollover   = 1'b0;
        if (i_latch_sel)
        begin
            if (i_tick)
            begin
                next_latched = count;
            end
        end
        else
        begin
            if (i_rd_low)
            begin
                next_latched = count;
            end
            if (i_rd_high)
            begin
                base = '0;
            end
        end
        next_count = base;
        // an error landing on the clearing read is still counted
        if (i_inc)
        begin
            if (base != CNT_MAX)
            begin
                next_count = base + 16'h0001;
            end
            else if (i_roll_en)
            begin
                next_count = '0;
                o_rollover = 1'b1;
            end
            else
            begin
                next_count = CNT_MAX;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            count   <= '0;
            latched <= '0;
        end
        else
        begin
            count   <= next_count;
            latched <= next_latched;
        end
    end

    // low byte live in read-latch mode so the read sees what it latches
    assign o_low  = i_latch_sel ? latched[7:0] : count[7:0];
    assign o_high = latched[15:8];

endmodule : fie_error_counter

`default_nettype wire

// ===== verilog/fie_edge_status.sv
`default_nettype none

module fie_edge_status
    import fie_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    input  wire logic [PAT_W-1:0] i_src,
    input  wire logic             i_clear,
    output logic [PAT_W-1:0]      o_status
);

    logic [PAT_W-1:0] prev;
    logic [PAT_W-1:0] next_status;

    always_comb
    begin
        // a rise in the clearing cycle survives the clear
        next_status = (i_clear ? '0 : o_status) | (i_src & ~prev);
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prev     <= '0;
            o_status <= '0;
        end
        else
        begin
            prev     <= i_src;
            o_status <= next_status;
        end
    end

endmodule : fie_edge_status

`default_nettype wire

// ===== verilog/fie_irq_enable_bank.sv
`default_nettype none

module fie_irq_enable_bank
    import fie_pkg::*;
(
    input  wire logic              I_CLOCK,
    input  wire logic              I_ARST_N,
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [DATA_W-1:0] I_WR_DATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic [DATA_W-1:0]      O_RD_DATA,
    output logic                   O_RD_VALID,
    input  wire logic [7:0]        I_ALARM_ONE_STATUS,
    input  wire logic              I_ANALOG_SIGNAL_LOSS,
    input  wire logic              I_RECEIVE_CLOCK_LOSS,
    input  wire logic [7:0]        I_ALARM_TWO_STATUS,
    input  wire logic [7:0]        I_ERROR_STATUS,
    input  wire logic [7:0]        I_TIMER_STATUS,
    input  wire logic [7:0]        I_LINK_ONE_STATUS,
    input  wire logic [7:0]        I_LINK_TWO_STATUS,
    input  wire logic [PAT_W-1:0]  I_PATTERN_SOURCE,
    input  wire logic [CNT_NUM-1:0] I_ERR_EVENT,
    input  wire logic              I_ONE_SEC_TICK,
    output logic [EN_COUNT-1:0]    O_GROUP_SUMMARY,
    output logic                   O_IRQ_OUT_N
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic en_hit(input logic [8:0] a);
        return (a >= EN_BASE_ADDR) && (a <= PATTERN_IRQ_ENABLE_ADDR);
    endfunction : en_hit

    // bank index falls as the offset rises
    function automatic logic [2:0] en_index(input logic [8:0] a);
        logic [8:0] d;
        d = a - EN_BASE_ADDR;
        return 3'(3'd7 - d[2:0]);
    endfunction : en_index

    function automatic logic cnt_hit(input logic [8:0] a);
        return a[8:4] == CNT_BASE_ADDR[8:4];
    endfunction : cnt_hit

    // ------------------------------------------------------------
    // enable registers and latch select
    // ------------------------------------------------------------
    logic [7:0] irq_enable_reg      [EN_COUNT];
    logic [7:0] next_irq_enable_reg [EN_COUNT];
    logic       one_second_latch_sel;
    logic       next_one_second_latch_sel;
    logic       en_wr;
    logic       latch_wr;

    assign en_wr    = I_WR && en_hit(I_ADDR);
    assign latch_wr = I_WR && (I_ADDR == LATCH_SEL_ADDR);

    // reserved positions are masked on the way in, so they read zero
    always_comb
    begin
        for (int n = 0; n < EN_COUNT; n++)
        begin
            next_irq_enable_reg[n] = irq_enable_reg[n];
        end
        next_one_second_latch_sel = one_second_latch_sel;
        if (en_wr)
        begin
            next_irq_enable_reg[en_index(I_ADDR)] =
                I_WR_DATA & EN_MASK[en_index(I_ADDR)];
        end
        if (latch_wr)
        begin
            next_one_second_latch_sel = I_WR_DATA[LATCH_SEL_BIT];
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            for (int n = 0; n < EN_COUNT; n++)
            begin
                irq_enable_reg[n] <= EN_RESET;
            end
            one_second_latch_sel <= LATCH_RESET;
        end
        else
        begin
            for (int n = 0; n < EN_COUNT; n++)
            begin
                irq_enable_reg[n] <= next_irq_enable_reg[n];
            end
            one_second_latch_sel <= next_one_second_latch_sel;
        end
    end

    // ------------------------------------------------------------
    // error counters
    // ------------------------------------------------------------
    logic [7:0]         cnt_low  [CNT_NUM];
    logic [7:0]         cnt_high [CNT_NUM];
    logic [CNT_NUM-1:0] rollover;
    logic [2:0]         cnt_sel;
    logic               cnt_rd;

    // low byte at even offset, high byte at odd
    assign cnt_sel = I_ADDR[3:1];
    assign cnt_rd  = I_RD && cnt_hit(I_ADDR);

    generate
        for (genvar k = 0; k < CNT_NUM; k++)
        begin : g_cnt
            fie_error_counter u_cnt (
                .i_clk       (I_CLOCK),
                .i_arst_n    (I_ARST_N),
                .i_inc       (I_ERR_EVENT[k]),
                .i_roll_en   (irq_enable_reg[GRP_OVERFLOW][k]),
                .i_latch_sel (one_second_latch_sel),
                .i_tick      (I_ONE_SEC_TICK),
                .i_rd_low    (cnt_rd && cnt_sel == 3'(k) && !I_ADDR[0]),
                .i_rd_high   (cnt_rd && cnt_sel == 3'(k) && I_ADDR[0]),
                .o_low       (cnt_low[k]),
                .o_high      (cnt_high[k]),
                .o_rollover  (rollover[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // overflow status, set only by a rollover
    // ------------------------------------------------------------
    logic [7:0] overflow_status;
    logic [7:0] next_overflow_status;
    logic       ovf_clear;

    // one read clears all eight flags; a rollover on that edge wins
    assign ovf_clear = I_RD && (I_ADDR == OVERFLOW_STATUS_ADDR);

    always_comb
    begin
        // saturating counters never pulse rollover, so no event
        next_overflow_status =
            (ovf_clear ? 8'h00 : overflow_status) | rollover;
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            overflow_status <= 8'h00;
        end
        else
        begin
            overflow_status <= next_overflow_status;
        end
    end

    // ------------------------------------------------------------
    // pattern status
    // ------------------------------------------------------------
    logic [PAT_W-1:0] pattern_status_reg;
    logic             pat_clear;

    // any read of the status word clears it, back to back too
    assign pat_clear = I_RD && (I_ADDR == PATTERN_STATUS_ADDR);

    fie_edge_status u_pattern (
        .i_clk    (I_CLOCK),
        .i_arst_n (I_ARST_N),
        .i_src    (I_PATTERN_SOURCE),
        .i_clear  (pat_clear),
        .o_status (pattern_status_reg)
    );

    // ------------------------------------------------------------
    // status gathering and summary
    // ------------------------------------------------------------
    logic [7:0] irq_status_reg [EN_COUNT];
    logic [7:0] alarm_one;

    always_comb
    begin
        alarm_one = I_ALARM_ONE_STATUS;
        alarm_one[SIGNAL_LOSS_BIT] =
            I_ANALOG_SIGNAL_LOSS | I_RECEIVE_CLOCK_LOSS;
    end

    assign irq_status_reg[GRP_ALARM_ONE] = alarm_one;
    assign irq_status_reg[GRP_ALARM_TWO] = I_ALARM_TWO_STATUS;
    assign irq_status_reg[GRP_ERROR]     = I_ERROR_STATUS;
    assign irq_status_reg[GRP_OVERFLOW]  = overflow_status;
    assign irq_status_reg[GRP_TIMER]     = I_TIMER_STATUS;
    assign irq_status_reg[GRP_LINK_ONE]  = I_LINK_ONE_STATUS;
    assign irq_status_reg[GRP_LINK_TWO]  = I_LINK_TWO_STATUS;
    assign irq_status_reg[GRP_PATTERN]   = {2'b00, pattern_status_reg};

    logic [EN_COUNT-1:0] next_summary;
    logic [EN_COUNT-1:0] group_summary_bit;

    always_comb
    begin
        for (int n = 0; n < EN_COUNT; n++)
        begin
            // cleared enables keep status visible but off the summary
            next_summary[n] =
                |(irq_status_reg[n] & irq_enable_reg[n]);
        end
    end

    // registered so status edges never glitch the interrupt pin
    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            group_summary_bit <= '0;
        end
        else
        begin
            group_summary_bit <= next_summary;
        end
    end

    assign O_GROUP_SUMMARY = group_summary_bit;
    assign O_IRQ_OUT_N     = ~|group_summary_bit;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_word;
    logic [7:0] next_rd_data;
    logic       next_rd_valid;

    always_comb
    begin
        rd_word = 8'h00;
        if (en_hit(I_ADDR))
        begin
            rd_word = irq_enable_reg[en_index(I_ADDR)];
        end
        else if (cnt_hit(I_ADDR))
        begin
            rd_word = I_ADDR[0] ? cnt_high[cnt_sel] : cnt_low[cnt_sel];
        end
        else if (I_ADDR == PATTERN_STATUS_ADDR)
        begin
            rd_word = irq_status_reg[GRP_PATTERN];
        end
        else if (I_ADDR == OVERFLOW_STATUS_ADDR)
        begin
            rd_word = overflow_status;
        end
        else if (I_ADDR == LATCH_SEL_ADDR)
        begin
            rd_word[LATCH_SEL_BIT] = one_second_latch_sel;
        end
    end

    // data holds between reads; a slow host may fetch it late
    always_comb
    begin
        next_rd_valid = I_RD;
        next_rd_data  = O_RD_DATA;
        if (I_RD)
        begin
            next_rd_data = rd_word;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_RD_DATA  <= 8'h00;
            O_RD_VALID <= 1'b0;
        end
        else
        begin
            O_RD_DATA  <= next_rd_data;
            O_RD_VALID <= next_rd_valid;
        end
    end

endmodule : fie_irq_enable_bank

`default_nettype wire

// ===== testbench/fie_irq_enable_bank_monitor.sv
`default_nettype none

module fie_irq_enable_bank_monitor
    import fie_pkg::*;
(
    input wire logic                I_CLOCK,
    input wire logic                I_ARST_N,
    input wire logic [ADDR_W-1:0]   I_ADDR,
    input wire logic [DATA_W-1:0]   I_WR_DATA,
    input wire logic                I_WR,
    input wire logic                I_RD,
    input wire logic [DATA_W-1:0]   O_RD_DATA,
    input wire logic                O_RD_VALID,
    input wire logic [7:0]          I_ALARM_ONE_STATUS,
    input wire logic                I_ANALOG_SIGNAL_LOSS,
    input wire logic                I_RECEIVE_CLOCK_LOSS,
    input wire logic [7:0]          I_ALARM_TWO_STATUS,
    input wire logic [7:0]          I_ERROR_STATUS,
    input wire logic [7:0]          I_TIMER_STATUS,
    input wire logic [7:0]          I_LINK_ONE_STATUS,
    input wire logic [7:0]          I_LINK_TWO_STATUS,
    input wire logic [PAT_W-1:0]    I_PATTERN_SOURCE,
    input wire logic [EN_COUNT-1:0] O_GROUP_SUMMARY,
    input wire logic                O_IRQ_OUT_N
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);

    // ------------------------------------------------------------
    // enable shadow, rebuilt from writes seen at the port
    // ------------------------------------------------------------
    logic [7:0]       en [EN_COUNT];
    logic [7:0]       next_en [EN_COUNT];
    logic             en_hit;
    logic [2:0]       en_idx;
    logic [7:0]       rd_val;
    logic [7:0]       alarm_one;
    logic [7:0]       exp_lvl;
    logic [PAT_W-1:0] pat_prev;
    logic [PAT_W-1:0] pat_rise;

    assign en_hit = I_ADDR >= ALARM_ONE_IRQ_ENABLE_ADDR
                 && I_ADDR <= PATTERN_IRQ_ENABLE_ADDR;
    assign en_idx = 3'(PATTERN_IRQ_ENABLE_ADDR - I_ADDR);
    assign rd_val = en[en_idx];
    assign alarm_one = {I_ALARM_ONE_STATUS[7:4],
        I_ANALOG_SIGNAL_LOSS | I_RECEIVE_CLOCK_LOSS, I_ALARM_ONE_STATUS[2:0]};
    assign exp_lvl = {|(alarm_one & en[7]), |(I_ALARM_TWO_STATUS & en[6]),
        |(I_ERROR_STATUS & en[5]), 1'b0, |(I_TIMER_STATUS & en[3]),
        |(I_LINK_ONE_STATUS & en[2]), |(I_LINK_TWO_STATUS & en[1]), 1'b0};
    assign pat_rise = I_PATTERN_SOURCE & ~pat_prev;

    always_comb
    begin
        next_en = en;
        if (I_WR && en_hit)
        begin
            next_en[en_idx] = I_WR_DATA & EN_MASK[en_idx];
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            en       <= '{default: EN_RESET};
            pat_prev <= '0;
        end
        else
        begin
            en       <= next_en;
            pat_prev <= I_PATTERN_SOURCE;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_irq_output_nor: assert property (
        O_IRQ_OUT_N == !(|O_GROUP_SUMMARY))
        else $error("irq output disagrees with summary");
    a_level_sum_eq: assert property (
        1 |=> (O_GROUP_SUMMARY & 8'hee) == $past(exp_lvl))
        else $error("level group summary wrong");
    a_alarm_one_sum: assert property (
        exp_lvl[GRP_ALARM_ONE] |=> O_GROUP_SUMMARY[GRP_ALARM_ONE])
        else $error("alarm one summary missing");
    a_error_gated: assert property (
        !exp_lvl[GRP_ERROR] |=> !O_GROUP_SUMMARY[GRP_ERROR])
        else $error("error summary without enabled status");
    a_pattern_set: assert property (
        |(pat_rise & en[GRP_PATTERN][PAT_W-1:0])
        ##1 $stable(en[GRP_PATTERN]) |=> O_GROUP_SUMMARY[GRP_PATTERN])
        else $error("pattern edge not reported");
    a_pattern_clear: assert property (
        I_RD && I_ADDR == PATTERN_STATUS_ADDR && pat_rise == '0
        |=> ##1 !O_GROUP_SUMMARY[GRP_PATTERN])
        else $error("pattern status survived read");
    a_no_sat_irq: assert property (
        en[GRP_OVERFLOW] == 8'h00 |=> !O_GROUP_SUMMARY[GRP_OVERFLOW])
        else $error("overflow summary with enables clear");
    a_enable_readback: assert property (
        I_RD && en_hit |=> O_RD_VALID && O_RD_DATA == $past(rd_val))
        else $error("enable readback wrong");

    c_irq_low: cover property (!O_IRQ_OUT_N);
    c_pattern: cover property ($rose(O_GROUP_SUMMARY[GRP_PATTERN]));
    c_overflow: cover property ($rose(O_GROUP_SUMMARY[GRP_OVERFLOW]));
endmodule : fie_irq_enable_bank_monitor

bind fie_irq_enable_bank fie_irq_enable_bank_monitor mon_u (.*);

`default_nettype wire

// ===== testbench/fie_irq_enable_bank_tb.sv
`default_nettype none

module fie_irq_enable_bank_tb
    import fie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk;
    logic                arst_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                wr;
    logic                rd;
    logic [DATA_W-1:0]   rdata;
    logic                rvalid;
    logic [7:0]          lvl [8];
    logic                los;
    logic                receive_clock_loss;
    logic                tick;
    logic [PAT_W-1:0]    pat;
    logic [CNT_NUM-1:0]  ev;
    logic [EN_COUNT-1:0] summ;
    logic                irq_n;
    int                  failures;
    int                  compares;

    fie_irq_enable_bank dut_u (
        .I_CLOCK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
        .I_WR_DATA(wdata), .I_WR(wr), .I_RD(rd), .O_RD_DATA(rdata),
        .O_RD_VALID(rvalid), .I_ALARM_ONE_STATUS(lvl[7]),
        .I_ANALOG_SIGNAL_LOSS(los), .I_RECEIVE_CLOCK_LOSS(receive_clock_loss),
        .I_ALARM_TWO_STATUS(lvl[6]), .I_ERROR_STATUS(lvl[5]),
        .I_TIMER_STATUS(lvl[3]), .I_LINK_ONE_STATUS(lvl[2]),
        .I_LINK_TWO_STATUS(lvl[1]), .I_PATTERN_SOURCE(pat),
        .I_ERR_EVENT(ev), .I_ONE_SEC_TICK(tick),
        .O_GROUP_SUMMARY(summ), .O_IRQ_OUT_N(irq_n)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // port tasks, all driven from the falling edge
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
    begin
        compares++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    end
    endtask : chk

    task automatic idle(input int n);
    begin
        repeat (n) @(negedge clk);
    end
    endtask : idle

    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    begin
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    end
    endtask : wr_reg

    task automatic rd_reg(input logic [8:0] a, input logic [7:0] e,
                          input string m);
    begin
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rvalid === 1'b1 && rdata === e, m);
    end
    endtask : rd_reg

    // one pulse train of n cycles; also used for the tick
    task automatic pulse_ev(input logic [7:0] m, input int n);
    begin
        @(negedge clk);
        ev = m;
        tick = (m == 8'h00);
        idle(n);
        ev = 8'h00;
        tick = 1'b0;
    end
    endtask : pulse_ev

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
    begin
        for (int n = 0; n < EN_COUNT; n++)
        begin
            rd_reg(PATTERN_IRQ_ENABLE_ADDR - 9'(n), EN_RESET,
                   "reset");
            wr_reg(PATTERN_IRQ_ENABLE_ADDR - 9'(n), 8'hff);
            rd_reg(PATTERN_IRQ_ENABLE_ADDR - 9'(n), EN_MASK[n],
                   "mask");
        end
        wr_reg(9'h1ff, 8'hff);
        rd_reg(9'h1ff, 8'h00, "unmapped");
    end
    endtask : t_regs

    task automatic t_gate();
        int bank [6] = '{7, 6, 5, 3, 2, 1};
        logic [8:0] a;
    begin
        foreach (bank[i])
        begin
            a = PATTERN_IRQ_ENABLE_ADDR - 9'(bank[i]);
            wr_reg(a, 8'h00);
            lvl[bank[i]] = 8'h80;
            idle(2);
            chk(summ[bank[i]] === 1'b0 && irq_n === 1'b1, "gated");
            wr_reg(a, 8'h80);
            idle(2);
            chk(summ[bank[i]] === 1'b1 && irq_n === 1'b0,
                "enabled");
            lvl[bank[i]] = 8'h00;
            idle(2);
            chk(irq_n === 1'b1, "released");
        end
        wr_reg(ALARM_ONE_IRQ_ENABLE_ADDR, 8'h08);
        lvl[7] = 8'h08;
        idle(2);
        chk(summ[7] === 1'b0, "plain bit 3 ignored");
        lvl[7] = 8'h00;
        los = 1'b1;
        idle(2);
        chk(summ[7] === 1'b1, "signal loss");
        los = 1'b0;
        idle(2);
        receive_clock_loss = 1'b1;
        idle(2);
        chk(summ[7] === 1'b1 && irq_n === 1'b0, "clock loss");
        receive_clock_loss = 1'b0;
        idle(2);
    end
    endtask : t_gate

    task automatic t_pattern();
    begin
        pat = 6'h20;
        idle(3);
        chk(summ[0] === 1'b1 && irq_n === 1'b0, "captured");
        rd_reg(PATTERN_STATUS_ADDR, 8'h20, "status");
        idle(2);
        chk(summ[0] === 1'b0 && irq_n === 1'b1, "cleared");
        rd_reg(PATTERN_STATUS_ADDR, 8'h00, "level not edge");
        pat = 6'h00;
        wr_reg(PATTERN_IRQ_ENABLE_ADDR, 8'h3e);
        pat = 6'h01;
        idle(3);
        chk(summ[0] === 1'b0, "disabled bit");
        rd_reg(PATTERN_STATUS_ADDR, 8'h01, "status kept");
        pat = 6'h00;
    end
    endtask : t_pattern

    task automatic t_count();
    begin
        wr_reg(COUNT_OVERFLOW_IRQ_ENABLE_ADDR, 8'h02);
        pulse_ev(8'h03, 65536);
        idle(3);
        chk(summ[4] === 1'b1 && irq_n === 1'b0, "rollover irq");
        rd_reg(OVERFLOW_STATUS_ADDR, 8'h02,
               "overflow flags");
        idle(2);
        chk(summ[4] === 1'b0, "overflow cleared");
        rd_reg(CNT_BASE_ADDR, 8'hff, "sat low");
        rd_reg(CNT_BASE_ADDR + 9'h001, 8'hff, "sat high");
        rd_reg(CNT_BASE_ADDR, 8'h00, "high read clears");
        rd_reg(CNT_BASE_ADDR + 9'h002, 8'h00, "rolled");
        pulse_ev(8'h08, 2);
        rd_reg(CNT_BASE_ADDR + 9'h006, 8'h02, "live low");
        rd_reg(CNT_BASE_ADDR + 9'h007, 8'h00, "latched high");
        rd_reg(CNT_BASE_ADDR + 9'h006, 8'h00, "cleared");
        wr_reg(LATCH_SEL_ADDR, 8'h01);
        pulse_ev(8'h04, 3);
        pulse_ev(8'h00, 1);
        pulse_ev(8'h04, 2);
        rd_reg(CNT_BASE_ADDR + 9'h004, 8'h03, "tick low");
        rd_reg(CNT_BASE_ADDR + 9'h005, 8'h00, "tick high");
        rd_reg(CNT_BASE_ADDR + 9'h004, 8'h03, "no clear");
        pulse_ev(8'h00, 1);
        rd_reg(CNT_BASE_ADDR + 9'h004, 8'h05, "next tick");
    end
    endtask : t_count

    task automatic tally_and_finish();
    begin
        if (failures == 0 && compares > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    end
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        failures = 0;
        compares = 0;
        arst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        lvl = '{default: 8'h00};
        los = 1'b0;
        receive_clock_loss = 1'b0;
        tick = 1'b0;
        pat = '0;
        ev = '0;
        idle(12);
        arst_n = 1'b1;
        t_regs();
        t_gate();
        t_pattern();
        t_count();
        tally_and_finish();
    end

    // the long count run dominates; about 66k cycles expected
    initial
    begin
        #(80000 * 20);
        failures++;
        tally_and_finish();
    end
endmodule : fie_irq_enable_bank_tb

`default_nettype wire
